// ### rtl/ext_port_pkg.sv
// Constants and types for the external memory expansion port master
package ext_port_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 24;
  localparam int ATTR_W = 4;
  localparam int WAIT_W = 5;
  // Register offsets of the plain register port
  localparam logic [3:0] OFS_BUS_CTRL = 4'h0;
  localparam logic [3:0] OFS_OP_MODE = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_RD_DATA = 4'h3;
  // Bus control register fields
  localparam int BCR_WAIT_LSB = 0;
  localparam int BCR_HOLE_BIT = 5;
  localparam int BCR_ROW_MODE_BIT = 6;
  localparam int BCR_ROW_POL_BIT = 7;
  localparam int BCR_ATTR_LSB = 8;
  // Operating mode register fields
  localparam int OMR_ACK_SYNC_BIT = 0;
  // Reset values
  localparam logic [11:0] BCR_RESET = 12'h001;
  localparam logic [0:0] OMR_RESET = 1'h0;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 5'h01;
  typedef enum logic [2:0] {
    ST_SLAVE, ST_WAIT_FREE, ST_IDLE, ST_ACCESS, ST_DONE
  } bus_state_e;
endpackage : ext_port_pkg

// ### rtl/ext_port_master.sv
// External memory expansion port master: pins, arbitration, wait states
`timescale 1ns/100ps
`default_nettype none
module ext_port_master (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core access request
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [ext_port_pkg::ADDR_W-1:0] acc_addr,
  input wire logic [ext_port_pkg::DATA_W-1:0] acc_wdata,
  output logic acc_done,
  output logic [ext_port_pkg::DATA_W-1:0] acc_rdata,
  input wire logic standby,
  // Arbitration
  output logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic bus_busy_n_in,
  output logic bus_busy_n_out,
  output logic bus_busy_n_oe_n,
  // Memory pins
  output logic [ext_port_pkg::ADDR_W-1:0] ext_addr,
  output logic ext_addr_oe_n,
  input wire logic [ext_port_pkg::DATA_W-1:0] ext_data_in,
  output logic [ext_port_pkg::DATA_W-1:0] ext_data_out,
  output logic ext_data_oe_n,
  output logic [ext_port_pkg::ATTR_W-1:0] addr_attribute,
  output logic addr_attribute_oe_n,
  output logic read_n,
  output logic write_n,
  output logic strobe_oe_n,
  input wire logic transfer_ack_n
);
  import ext_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [11:0] bcr_q;
  logic [0:0] omr_q;
  bus_state_e state_q;
  logic [WAIT_W-1:0] wait_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic write_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_async_q;
  logic ack_seen;
  logic master;
  logic in_cycle;
  logic row_mode;
  logic stretch_ok;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bcr_q <= BCR_RESET;
      omr_q <= OMR_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_BUS_CTRL)
        bcr_q <= reg_wdata[11:0];
      if (reg_addr == OFS_OP_MODE)
        omr_q <= reg_wdata[0:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      unique case (reg_addr)
        OFS_BUS_CTRL: reg_rdata <= {20'h0_0000, bcr_q};
        OFS_OP_MODE: reg_rdata <= {31'h0000_0000, omr_q};
        OFS_STATUS: reg_rdata <= {28'h000_0000, master, in_cycle,
          ~bus_request_n, standby};
        OFS_RD_DATA: reg_rdata <= {8'h00, rdata_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    else
      reg_rdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  assign row_mode = bcr_q[BCR_ROW_MODE_BIT];
  assign master = (state_q != ST_SLAVE) && (state_q != ST_WAIT_FREE);
  assign in_cycle = (state_q == ST_ACCESS);

  // Sync-bit path has a two-flop synchroniser; the other path uses one register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_async_q <= 1'b0;
    end else begin
      ack_s1_q <= ~transfer_ack_n;
      ack_s2_q <= ack_s1_q;
      ack_async_q <= ~transfer_ack_n;
    end
  end
  // Sync mode: pin taken through the two-flop synchroniser; otherwise one register
  assign ack_seen = omr_q[OMR_ACK_SYNC_BIT] ? ack_s2_q : ack_async_q;
  // Zero-wait or row strobe access is never stretched
  assign stretch_ok = !row_mode && (bcr_q[WAIT_W-1:0] != 5'h00);

  always_ff @(posedge clk) begin
    if (!reset_n || standby) begin
      state_q <= ST_SLAVE;
    end else begin
      unique case (state_q)
        ST_SLAVE:
          if (!bus_grant_n && req_q)
            state_q <= ST_WAIT_FREE;
        ST_WAIT_FREE:
          if (bus_grant_n)
            state_q <= ST_SLAVE;
          else if (bus_busy_n_in)
            state_q <= ST_IDLE;
        ST_IDLE:
          if (bus_grant_n)
            state_q <= ST_SLAVE;
          else if (acc_req)
            state_q <= ST_ACCESS;
        ST_ACCESS:
          // Programmed minimum first, then acknowledge if stretching allowed
          if (wait_q == 5'h00 && (!stretch_ok || ack_seen))
            state_q <= ST_DONE;
        ST_DONE:
          state_q <= bus_grant_n ? ST_SLAVE : ST_IDLE;
        default: state_q <= ST_SLAVE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n)
      wait_q <= 5'h00;
    else if (state_q == ST_IDLE)
      wait_q <= bcr_q[BCR_WAIT_LSB +: WAIT_W];
    else if (in_cycle && wait_q != 5'h00)
      wait_q <= wait_q - WAIT_ONE;
  end

  // Address held between cycles to avoid needless toggling
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_q <= '0;
      wdata_q <= '0;
      write_q <= 1'b0;
    end else if (state_q == ST_IDLE && acc_req && !bus_grant_n &&
        !standby) begin
      addr_q <= acc_addr;
      wdata_q <= acc_wdata;
      write_q <= acc_write;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n)
      rdata_q <= '0;
    else if (in_cycle && !write_q)
      rdata_q <= ext_data_in;
  end

  // Request tracks external needs and the hole bit only
  always_ff @(posedge clk) begin
    if (!reset_n || standby)
      req_q <= 1'b0;
    else
      req_q <= acc_req || bcr_q[BCR_HOLE_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus_request_n = ~req_q;
  assign acc_done = (state_q == ST_DONE);
  assign acc_rdata = rdata_q;
  assign ext_addr = addr_q;
  assign ext_addr_oe_n = ~master;
  assign ext_data_out = wdata_q;
  assign ext_data_oe_n = ~(in_cycle && write_q);
  assign strobe_oe_n = ~master;
  assign read_n = ~(in_cycle && !write_q);
  assign write_n = ~(in_cycle && write_q);
  assign bus_busy_n_out = ~master;
  assign bus_busy_n_oe_n = ~master;
  assign addr_attribute_oe_n = ~master;
  // Row mode: strobe active only during the cycle, polarity programmable
  assign addr_attribute = row_mode ?
    {ATTR_W{in_cycle ~^ bcr_q[BCR_ROW_POL_BIT]}} :
    bcr_q[BCR_ATTR_LSB +: ATTR_W];

  ////////////////////////////////////////////////////////////////////////
  // Last access cycle with acknowledge seen, then a one-cycle done pulse
  sequence s_ack_last;
    in_cycle && wait_q == 5'h00 && ack_seen && !standby;
  endsequence
  sequence s_done_pulse;
    acc_done ##1 !acc_done;
  endsequence
  a_standby_float: assert property (
    @(posedge clk) disable iff (!reset_n)
    standby |=> ext_addr_oe_n && strobe_oe_n && ext_data_oe_n)
    else $error("port not floated in standby");
  a_addr_owner: assert property (
    @(posedge clk) disable iff (!reset_n)
    !ext_addr_oe_n |-> master)
    else $error("address driven while not master");
  a_addr_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_ACCESS |=> $stable(ext_addr))
    else $error("address moved mid cycle");
  a_data_drive: assert property (
    @(posedge clk) disable iff (!reset_n)
    !ext_data_oe_n |-> master && !write_n)
    else $error("data driven outside write");
  a_read_float: assert property (
    @(posedge clk) disable iff (!reset_n)
    !master |-> strobe_oe_n && read_n && write_n)
    else $error("strobe active while slave");
  a_ack_ends: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_ack_last |=> s_done_pulse)
    else $error("cycle end not one clock after acknowledge");
  a_min_wait: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(in_cycle) && bcr_q[4:0] == 5'h04 |-> !acc_done[*5])
    else $error("cycle shorter than programmed");
  a_req_reset: assert property (
    @(posedge clk)
    !reset_n |=> bus_request_n && !master)
    else $error("request active after reset");
  a_strobe_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_IDLE |-> read_n && write_n)
    else $error("strobe active between cycles");
  // Stretching only counts once the programmed minimum has run out
  a_stretch_wait: assert property (
    @(posedge clk) disable iff (!reset_n)
    in_cycle && wait_q == 5'h00 && stretch_ok && !ack_seen && !standby
    |=> in_cycle)
    else $error("cycle ended without acknowledge");
  a_ack_ignored: assert property (
    @(posedge clk) disable iff (!reset_n)
    !in_cycle |=> !acc_done)
    else $error("cycle end outside an access");
  a_attr_value: assert property (
    @(posedge clk) disable iff (!reset_n)
    !row_mode |-> addr_attribute == bcr_q[BCR_ATTR_LSB +: ATTR_W])
    else $error("attribute outputs differ from programmed value");
  a_row_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    row_mode && !in_cycle |->
    addr_attribute == {ATTR_W{!bcr_q[BCR_ROW_POL_BIT]}})
    else $error("row strobe active outside a cycle");
  a_req_need: assert property (
    @(posedge clk) disable iff (!reset_n)
    acc_req && !standby |=> !bus_request_n)
    else $error("request missing for external access");
  a_req_drop: assert property (
    @(posedge clk) disable iff (!reset_n)
    !acc_req && !bcr_q[BCR_HOLE_BIT] |=> bus_request_n)
    else $error("request held without need");
  a_hole_req: assert property (
    @(posedge clk) disable iff (!reset_n)
    bcr_q[BCR_HOLE_BIT] && !standby |=> !bus_request_n)
    else $error("request hole did not raise request");
  a_grant_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_IDLE && bus_grant_n && !standby |=> !master)
    else $error("bus kept after grant withdrawn");
endmodule : ext_port_master
`default_nettype wire

// ### tb/mem_arb_model.sv
// Memory and bus arbiter model beside the expansion port
`timescale 1ns/100ps
`default_nettype none
module mem_arb_model (
  // Clock
  input wire logic clk,
  // Port pins seen from outside
  input wire logic bus_request_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic strobe_oe_n,
  // Acknowledge delay in cycles
  input wire logic [7:0] ack_wait,
  // Answers
  output logic bus_grant_n,
  output logic transfer_ack_n,
  output logic [23:0] ext_data_in
);
  logic [7:0] cnt_q;
  logic act;
  // Unknown enable before reset counts as idle so data never turns unknown
  assign act = (strobe_oe_n === 1'b0) && !(read_n && write_n);
  initial begin
    bus_grant_n = 1'b1;
    transfer_ack_n = 1'b1;
    ext_data_in = 24'h000000;
    cnt_q = 8'h00;
  end
  always @(posedge clk) begin
    bus_grant_n <= bus_request_n;
    cnt_q <= act ? cnt_q + 8'h01 : 8'h00;
    // Released high between cycles, low only after the delay
    transfer_ack_n <= !(act && cnt_q >= ack_wait);
    // Undriven data toggles so a stale sample never looks right
    ext_data_in <= (act && !read_n) ? 24'h5a1c3e : ~ext_data_in;
  end
endmodule : mem_arb_model
`default_nettype wire

// ### tb/tb_external_memory_port_master.sv
// Testbench for the expansion port master
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,s) begin samples_checked++; if ((s) !== (e)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_external_memory_port_master;
  import ext_port_pkg::*;
  logic clk, reset_n, reg_wr, reg_rd, acc_req, acc_write, acc_done;
  logic standby, bus_request_n, bus_grant_n, busy_out, busy_oe_n;
  logic addr_oe_n, data_oe_n, attr_oe_n, read_n, write_n, strobe_oe_n;
  logic transfer_ack_n, busy_wire;
  logic [3:0] reg_addr, attr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [17:0] acc_addr, ext_addr;
  logic [23:0] acc_wdata, acc_rdata, d_in, d_out;
  logic [7:0] ack_wait;
  logic [3:0] attr_seen;
  logic [31:0] rd_val;
  int err_total = 0;
  int samples_checked = 0;
  assign busy_wire = busy_oe_n ? 1'b1 : busy_out;
  ext_port_master i_ext_port_master (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .standby(standby),
    .bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n),
    .bus_busy_n_in(busy_wire), .bus_busy_n_out(busy_out),
    .bus_busy_n_oe_n(busy_oe_n), .ext_addr(ext_addr),
    .ext_addr_oe_n(addr_oe_n), .ext_data_in(d_in), .ext_data_out(d_out),
    .ext_data_oe_n(data_oe_n), .addr_attribute(attr),
    .addr_attribute_oe_n(attr_oe_n), .read_n(read_n), .write_n(write_n),
    .strobe_oe_n(strobe_oe_n), .transfer_ack_n(transfer_ack_n));
  mem_arb_model i_mem_arb_model (.clk(clk), .bus_request_n(bus_request_n),
    .read_n(read_n), .write_n(write_n), .strobe_oe_n(strobe_oe_n),
    .ack_wait(ack_wait), .bus_grant_n(bus_grant_n),
    .transfer_ack_n(transfer_ack_n), .ext_data_in(d_in));
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic access(input logic w, input logic [17:0] a, output int n);
    int t;
    n = 0;
    t = 0;
    @(posedge clk);
    acc_write <= w;
    acc_addr <= a;
    acc_req <= 1'b1;
    do begin
      @(negedge clk);
      t++;
      if (!read_n || !write_n) begin
        n++;
        attr_seen = attr;
        `CHK("addr", a, ext_addr)
        `CHK("own", 2'b00, {addr_oe_n, strobe_oe_n})
        `CHK("ownb", 2'b00, {attr_oe_n, busy_wire})
      end
      if (!write_n) `CHK("wdata", acc_wdata, d_out)
      `CHK("doe", write_n, data_oe_n)
    end while (acc_done !== 1'b1 && t < 300);
    `CHK("done", 1'b1, acc_done)
    @(posedge clk);
    acc_req <= 1'b0;
    @(negedge clk);
    `CHK("idle", 2'b11, {read_n, write_n})
  endtask : access
  task automatic s_reset();
    `CHK("rst", 2'b11, {bus_request_n, addr_oe_n})
    `CHK("rsto", 3'h7, {data_oe_n, strobe_oe_n, busy_oe_n})
    rd(OFS_BUS_CTRL, rd_val);
    `CHK("bcr", 32'h00000001, rd_val)
    rd(OFS_STATUS, rd_val);
    `CHK("stat", 32'h00000000, rd_val)
  endtask : s_reset
  task automatic s_waits();
    int n;
    ack_wait <= 8'h00;
    wr(OFS_BUS_CTRL, 32'h00000004);
    access(1'b0, 18'h2a5c3, n);
    `CHK("wait", 5, n)
    `CHK("rdat", 24'h5a1c3e, acc_rdata)
    rd(OFS_RD_DATA, rd_val);
    `CHK("rdreg", 32'h005a1c3e, rd_val)
  endtask : s_waits
  task automatic s_ack();
    int n;
    wr(OFS_BUS_CTRL, 32'h00000001);
    ack_wait <= 8'h06;
    for (int m = 0; m < 2; m++) begin
      wr(OFS_OP_MODE, m);
      access(1'b0, 18'h01234, n);
      `CHK("long", 1'b1, n > 6)
      `CHK("end", 1'b1, n <= 10)
      `CHK("lat", 9 + m, n)
    end
  endtask : s_ack
  task automatic s_write_release();
    int n;
    @(posedge clk);
    acc_wdata <= 24'hc3a50f;
    access(1'b1, 18'h3fffe, n);
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK("rel", 1'b1, addr_oe_n)
    `CHK("hold", 18'h3fffe, ext_addr)
  endtask : s_write_release
  task automatic s_attr();
    int n;
    wr(OFS_BUS_CTRL, 32'h00000a01);
    @(negedge clk);
    `CHK("attr", 4'ha, attr)
    access(1'b0, 18'h00155, n);
    `CHK("attrc", 4'ha, attr_seen)
    // Row strobe accesses are never stretched by the acknowledge
    ack_wait <= 8'h00;
    for (int p = 0; p < 2; p++) begin
      wr(OFS_BUS_CTRL, p ? 32'h000000c1 : 32'h00000041);
      @(negedge clk);
      `CHK("ras", p ? 4'h0 : 4'hf, attr)
      access(1'b0, 18'h00aaa, n);
      `CHK("rasc", p ? 4'hf : 4'h0, attr_seen)
      `CHK("rasn", 2, n)
    end
  endtask : s_attr
  task automatic s_hole();
    wr(OFS_BUS_CTRL, 32'h00000021);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("hole", 1'b0, bus_request_n)
    rd(OFS_STATUS, rd_val);
    `CHK("park", 32'h0000000a, rd_val)
    @(posedge clk);
    standby <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK("stby", 4'hf, {addr_oe_n, strobe_oe_n, attr_oe_n, busy_oe_n})
  endtask : s_hole
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, acc_req, acc_write, standby} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    acc_addr = 18'h00000;
    acc_wdata = 24'h000000;
    ack_wait = 8'h00;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    s_reset();
    s_waits();
    s_ack();
    s_write_release();
    s_attr();
    s_hole();
    finish_test();
  end
endmodule : tb_external_memory_port_master
`default_nettype wire
